// ===== hdl/ssf_pkg.sv
// package: register map, fields and timing for the system status flag bank
package ssf_pkg;

  localparam logic [11:0] OFF_STATUS    = 12'h000;
  localparam logic [11:0] OFF_CONTROL   = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h008;
  localparam logic [11:0] OFF_IRQ_EN    = 12'h00C;
  localparam logic [11:0] OFF_IRQ_CLR   = 12'h010;
  localparam logic [11:0] OFF_CLK_WORD0 = 12'h020;
  localparam logic [11:0] OFF_CLK_WORD1 = 12'h024;
  localparam logic [11:0] OFF_CLK_WORD2 = 12'h028;
  localparam logic [11:0] OFF_CLK_WORD3 = 12'h02C;

  // status register bit positions
  localparam int BIT_FUSE      = 0;
  localparam int BIT_PWR_DOWN  = 1;
  localparam int BIT_BAT_LIVE  = 2;
  localparam int BIT_BAT_LATCH = 3;
  localparam int BIT_SELFCHK   = 4;
  localparam int BIT_DIAG      = 5;
  localparam int BIT_CLK_ERR   = 6;
  localparam int NUM_EVENTS    = 7;

  // control register bit positions
  localparam int BIT_CLK_WRITE = 0;
  localparam int BIT_CLK_READ  = 1;
  localparam int BIT_BAT_USE   = 2;
  localparam int BIT_SUPPLY_DC = 3;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] ZERO_HALF = 16'h0000;
  localparam logic [3:0]  BCD_MAX   = 4'h9;

  // interruption windows per supply type
  localparam int  CLK_PERIOD_PS = 4000;
  localparam int  AC_WINDOW_MS  = 20;
  localparam int  DC_WINDOW_MS  = 10;
  localparam longint AC_CYCLES_L =
    (64'(AC_WINDOW_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);
  localparam longint DC_CYCLES_L =
    (64'(DC_WINDOW_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);
  localparam logic [23:0] AC_CYCLES = 24'(AC_CYCLES_L);
  localparam logic [23:0] DC_CYCLES = 24'(DC_CYCLES_L);
  localparam logic [23:0] ONE_CYCLE = 24'h00_0001;

  // raw fault inputs travelling together
  typedef struct packed {
    logic fuse_blown;
    logic supply_lost;
    logic battery_low;
    logic selfcheck_err;
    logic diag_err;
  } ssf_fault_type;

  // one pass of the main processing loop sees these requests
  typedef struct packed {
    logic write_req;
    logic read_req;
  } ssf_req_type;

  typedef enum logic [1:0] {
    PD_IDLE,
    PD_LOST,
    PD_DONE
  } ssf_pd_state_type;

endpackage

// ===== hdl/ssf_sticky.sv
// sticky event bit: set wins over clear
`timescale 1ns/1ns
`default_nettype none
module ssf_sticky (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_q
);

  logic flag_d;

  assign flag_d = set_in | (flag_q & ~clr_in);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/ssf_flag_bank.sv
// system status flag bank with AHB-Lite register access
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - a blown output-module fuse sets the fuse flag, which stays set.
// - on AC supply, an interruption under 20 ms sets the power-down flag.
// - on DC supply, an interruption under 10 ms sets the power-down flag.
// - the live battery-low flag follows the battery condition.
// - the latched battery-low flag sets on low battery and stays set.
// - battery flags update only while external battery use is enabled.
// - the battery indicator output follows the latched battery-low flag state.
// - a self-diagnosis error sets a flag that stays set.
// - a diagnosis error sets a flag that stays set.
// - a rising edge of the write request copies the four words out.
// - invalid words on a write request set the clock data error flag.
// - while read request is high the current BCD time loads the words.
module ssf_flag_bank (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire ssf_pkg::ssf_fault_type faults,
  input  wire logic                   pass_tick,
  input  wire logic [31:0]            rtc_time_bcd,
  output logic      [31:0]            rtc_set_time,
  output logic                        rtc_set_strobe,
  output logic                        battery_indicator,
  output logic                        irq
);

  // bus address phase capture
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic        rd_pend_q;
  logic [11:0] rd_addr_q;
  logic        addr_ok;

  assign addr_ok   = hsel & hready & htrans[1];
  // every register answers at once: no wait states
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rd_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      rd_pend_q <= addr_ok & ~hwrite;
      wr_addr_q <= haddr[11:0];
      rd_addr_q <= haddr[11:0];
    end
  end

  // write decode in the data phase
  wire wr_ctrl  = wr_pend_q && (wr_addr_q == ssf_pkg::OFF_CONTROL);
  wire wr_en    = wr_pend_q && (wr_addr_q == ssf_pkg::OFF_IRQ_EN);
  wire wr_clr   = wr_pend_q && (wr_addr_q == ssf_pkg::OFF_IRQ_CLR);
  wire wr_word0 = wr_pend_q && (wr_addr_q == ssf_pkg::OFF_CLK_WORD0);
  wire wr_word1 = wr_pend_q && (wr_addr_q == ssf_pkg::OFF_CLK_WORD1);
  wire wr_word2 = wr_pend_q && (wr_addr_q == ssf_pkg::OFF_CLK_WORD2);
  wire wr_word3 = wr_pend_q && (wr_addr_q == ssf_pkg::OFF_CLK_WORD3);

  // control register: request bits, battery use, supply type
  logic [3:0] ctrl_q;
  logic [3:0] ctrl_d;
  assign ctrl_d = wr_ctrl ? hwdata[3:0] : ctrl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 4'h0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  wire bat_use   = ctrl_q[ssf_pkg::BIT_BAT_USE];
  wire supply_dc = ctrl_q[ssf_pkg::BIT_SUPPLY_DC];

  // request sampling per main pass
  // edge shows one pass after its sample: a set takes two passes
  ssf_pkg::ssf_req_type req_q;
  ssf_pkg::ssf_req_type req_prev_q;
  ssf_pkg::ssf_req_type req_d;
  ssf_pkg::ssf_req_type prev_d;

  assign req_d.write_req = pass_tick ? ctrl_q[ssf_pkg::BIT_CLK_WRITE]
                                     : req_q.write_req;
  assign req_d.read_req  = pass_tick ? ctrl_q[ssf_pkg::BIT_CLK_READ]
                                     : req_q.read_req;
  assign prev_d          = pass_tick ? req_q : req_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q      <= '0;
      req_prev_q <= '0;
    end else begin
      req_q      <= req_d;
      req_prev_q <= prev_d;
    end
  end

  // one pulse per off-to-on of the sampled write request
  logic wr_edge_q;
  wire  wr_edge = pass_tick & req_q.write_req & ~req_prev_q.write_req;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_edge_q <= 1'b0;
    end else begin
      wr_edge_q <= wr_edge;
    end
  end

  // four clock data words, 16 bits each, only the low byte of each used
  logic [15:0] word0_q;
  logic [15:0] word1_q;
  logic [15:0] word2_q;
  logic [15:0] word3_q;
  wire         rd_load = pass_tick & req_q.read_req;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word0_q <= ssf_pkg::ZERO_HALF;
      word1_q <= ssf_pkg::ZERO_HALF;
      word2_q <= ssf_pkg::ZERO_HALF;
      word3_q <= ssf_pkg::ZERO_HALF;
    end else if (rd_load) begin
      // read request wins: the words mirror the clock element
      word0_q <= rtc_time_bcd[7:0] == 8'h00 ? ssf_pkg::ZERO_HALF
                                            : {8'h00, rtc_time_bcd[7:0]};
      word1_q <= {8'h00, rtc_time_bcd[15:8]};
      word2_q <= {8'h00, rtc_time_bcd[23:16]};
      word3_q <= {8'h00, rtc_time_bcd[31:24]};
    end else begin
      if (wr_word0) word0_q <= hwdata[15:0];
      if (wr_word1) word1_q <= hwdata[15:0];
      if (wr_word2) word2_q <= hwdata[15:0];
      if (wr_word3) word3_q <= hwdata[15:0];
    end
  end

  // every nibble of the low bytes must be a BCD digit
  logic [31:0] set_word;
  logic        bcd_bad;
  assign set_word = {word3_q[7:0], word2_q[7:0], word1_q[7:0], word0_q[7:0]};

  always_comb begin
    bcd_bad = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (set_word[i*4 +: 4] > ssf_pkg::BCD_MAX) bcd_bad = 1'b1;
    end
  end

  // clock element write: the set time loads any data; only valid data is strobed
  // bad data blocks the strobe so the clock keeps its old time
  logic [31:0] set_time_q;
  logic        set_strobe_q;
  logic        clk_err_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      set_time_q   <= ssf_pkg::ZERO_WORD;
      set_strobe_q <= 1'b0;
      clk_err_q    <= 1'b0;
    end else begin
      set_strobe_q <= wr_edge_q & ~bcd_bad;
      if (wr_edge_q) begin
        set_time_q <= set_word;
        clk_err_q  <= bcd_bad;
      end
    end
  end

  assign rtc_set_time   = set_time_q;
  assign rtc_set_strobe = set_strobe_q;

  // power-down: measure the loss; a short one is a momentary interruption
  // counter stops at the limit, so a long outage cannot wrap round
  ssf_pkg::ssf_pd_state_type pd_state_q;
  ssf_pkg::ssf_pd_state_type pd_state_d;
  logic [23:0]               pd_cnt_q;
  logic [23:0]               pd_cnt_d;
  logic                      pd_flag_q;
  logic                      pd_set;
  wire  [23:0]               pd_limit = supply_dc ? ssf_pkg::DC_CYCLES
                                                  : ssf_pkg::AC_CYCLES;

  always_comb begin
    pd_state_d = pd_state_q;
    pd_cnt_d   = pd_cnt_q;
    pd_set     = 1'b0;
    case (pd_state_q)
      ssf_pkg::PD_IDLE: begin
        if (faults.supply_lost) begin
          pd_state_d = ssf_pkg::PD_LOST;
          pd_cnt_d   = ssf_pkg::ONE_CYCLE;
        end
      end
      ssf_pkg::PD_LOST: begin
        if (!faults.supply_lost) begin
          pd_set     = pd_cnt_q < pd_limit;
          pd_state_d = ssf_pkg::PD_IDLE;
        end else if (pd_cnt_q >= pd_limit) begin
          // a longer loss is a real power-off, not a momentary dip
          pd_state_d = ssf_pkg::PD_DONE;
        end else begin
          pd_cnt_d = pd_cnt_q + ssf_pkg::ONE_CYCLE;
        end
      end
      default: begin
        if (!faults.supply_lost) pd_state_d = ssf_pkg::PD_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd_state_q <= ssf_pkg::PD_IDLE;
      pd_cnt_q   <= 24'h00_0000;
      pd_flag_q  <= 1'b0;
    end else begin
      pd_state_q <= pd_state_d;
      pd_cnt_q   <= pd_cnt_d;
      // only a power cycle (hresetn) clears it
      if (pd_set) pd_flag_q <= 1'b1;
    end
  end

  // battery flags, gated by the battery use setting
  // with battery use off both flags keep their last value
  logic bat_live_q;
  logic bat_latch_q;
  logic fuse_q;
  logic selfchk_q;
  logic diag_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bat_live_q  <= 1'b0;
      bat_latch_q <= 1'b0;
      fuse_q      <= 1'b0;
      selfchk_q   <= 1'b0;
      diag_q      <= 1'b0;
    end else begin
      if (bat_use) begin
        bat_live_q <= faults.battery_low;
        if (faults.battery_low) bat_latch_q <= 1'b1;
      end
      if (faults.fuse_blown) fuse_q <= 1'b1;
      if (faults.selfcheck_err) selfchk_q <= 1'b1;
      if (faults.diag_err) diag_q <= 1'b1;
    end
  end

  assign battery_indicator = bat_live_q | bat_latch_q;

  // status word
  logic [ssf_pkg::NUM_EVENTS-1:0] status;
  assign status[ssf_pkg::BIT_FUSE]      = fuse_q;
  assign status[ssf_pkg::BIT_PWR_DOWN]  = pd_flag_q;
  assign status[ssf_pkg::BIT_BAT_LIVE]  = bat_live_q;
  assign status[ssf_pkg::BIT_BAT_LATCH] = bat_latch_q;
  assign status[ssf_pkg::BIT_SELFCHK]   = selfchk_q;
  assign status[ssf_pkg::BIT_DIAG]      = diag_q;
  assign status[ssf_pkg::BIT_CLK_ERR]   = clk_err_q;

  // interrupt events: rising edge of each flag
  // edge-based: a flag that stays high raises its event only once
  logic [ssf_pkg::NUM_EVENTS-1:0] status_prev_q;
  logic [ssf_pkg::NUM_EVENTS-1:0] irq_stat_q;
  logic [ssf_pkg::NUM_EVENTS-1:0] irq_en_q;
  wire  [ssf_pkg::NUM_EVENTS-1:0] ev = status & ~status_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_prev_q <= '0;
      irq_en_q      <= '0;
    end else begin
      status_prev_q <= status;
      if (wr_en) irq_en_q <= hwdata[ssf_pkg::NUM_EVENTS-1:0];
    end
  end

  // set wins over clear, so an event in the clear cycle is kept
  genvar g;
  generate
    for (g = 0; g < ssf_pkg::NUM_EVENTS; g++) begin : g_evt
      ssf_sticky u_sticky (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set_in  (ev[g]),
        .clr_in  (wr_clr & hwdata[g]),
        .flag_q  (irq_stat_q[g])
      );
    end
  endgenerate

  assign irq = |(irq_stat_q & irq_en_q);

  // read mux; unmapped addresses read zero
  logic [31:0] rd_d;

  always_comb begin
    if (rd_addr_q == ssf_pkg::OFF_STATUS) begin
      rd_d = {25'h0, status};
    end else if (rd_addr_q == ssf_pkg::OFF_CONTROL) begin
      rd_d = {28'h0, ctrl_q};
    end else if (rd_addr_q == ssf_pkg::OFF_IRQ_STAT) begin
      rd_d = {25'h0, irq_stat_q};
    end else if (rd_addr_q == ssf_pkg::OFF_IRQ_EN) begin
      rd_d = {25'h0, irq_en_q};
    end else if (rd_addr_q == ssf_pkg::OFF_CLK_WORD0) begin
      rd_d = {16'h0, word0_q};
    end else if (rd_addr_q == ssf_pkg::OFF_CLK_WORD1) begin
      rd_d = {16'h0, word1_q};
    end else if (rd_addr_q == ssf_pkg::OFF_CLK_WORD2) begin
      rd_d = {16'h0, word2_q};
    end else if (rd_addr_q == ssf_pkg::OFF_CLK_WORD3) begin
      rd_d = {16'h0, word3_q};
    end else begin
      rd_d = ssf_pkg::ZERO_WORD;
    end
  end

  // zero-wait read: data valid in the data phase cycle
  // a mux of registers, gated so idle cycles show zero
  assign hrdata = rd_pend_q ? rd_d : ssf_pkg::ZERO_WORD;

endmodule
`default_nettype wire

// ===== testbench/ssf_flag_bank_chk.sv
// checker: port-level assertions for the flag bank
`timescale 1ns/1ns
`default_nettype none
module ssf_flag_bank_chk (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire ssf_pkg::ssf_fault_type faults,
  input wire logic                   pass_tick,
  input wire logic [31:0]            rtc_set_time,
  input wire logic                   rtc_set_strobe,
  input wire logic                   battery_indicator
);
  logic       dph_q;
  logic       rds_q;
  logic [2:0] seen_q;
  logic [2:0] d1_q;
  logic [2:0] d2_q;
  logic [2:0] d3_q;
  logic       bcd_ok;
  wire logic  take = hsel && hready && htrans[1];
  // delayed seen flags leave three cycles of slack for a fault synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {dph_q, rds_q, seen_q, d1_q, d2_q, d3_q} <= '0;
    end else begin
      dph_q <= take;
      rds_q <= take && !hwrite && haddr[11:0] == ssf_pkg::OFF_STATUS;
      seen_q <= seen_q | {faults.fuse_blown, faults.selfcheck_err,
                          faults.diag_err};
      {d1_q, d2_q, d3_q} <= {seen_q, d1_q, d2_q};
    end
  end
  always_comb begin
    bcd_ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      bcd_ok &= (rtc_set_time[4*i +: 4] <= ssf_pkg::BCD_MAX);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_one_pulse;
    rtc_set_strobe ##1 !rtc_set_strobe;
  endsequence
  property p_okay;
    hreadyout && !hresp;
  endproperty
  property p_rdata_idle;
    !dph_q |-> hrdata == 32'h0000_0000;
  endproperty
  property p_bat_hold;
    battery_indicator |=> battery_indicator;
  endproperty
  property p_bat_rise;
    $rose(battery_indicator) |-> faults.battery_low ||
      $past(faults.battery_low) || $past(faults.battery_low, 2);
  endproperty
  property p_strobe_pulse;
    $rose(rtc_set_strobe) |-> s_one_pulse;
  endproperty
  property p_strobe_tick;
    rtc_set_strobe |-> $past(pass_tick) || $past(pass_tick, 2) ||
      $past(pass_tick, 3);
  endproperty
  property p_set_bcd;
    rtc_set_strobe |-> bcd_ok;
  endproperty
  property p_fuse;
    rds_q && d3_q[2] |-> hrdata[ssf_pkg::BIT_FUSE];
  endproperty
  property p_selfchk;
    rds_q && d3_q[1] |-> hrdata[ssf_pkg::BIT_SELFCHK];
  endproperty
  property p_diag;
    rds_q && d3_q[0] |-> hrdata[ssf_pkg::BIT_DIAG];
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus not ready or not okay");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside data phase");
  a_bat_hold: assert property (p_bat_hold)
    else $error("battery indicator dropped");
  a_bat_rise: assert property (p_bat_rise)
    else $error("battery indicator rose without low battery");
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("set strobe longer than one cycle");
  a_strobe_tick: assert property (p_strobe_tick)
    else $error("set strobe without a pass");
  a_set_bcd: assert property (p_set_bcd)
    else $error("invalid time written to clock");
  a_fuse: assert property (p_fuse)
    else $error("fuse flag not held");
  a_selfchk: assert property (p_selfchk)
    else $error("self-check flag not held");
  a_diag: assert property (p_diag)
    else $error("diagnostic flag not held");
endmodule
bind ssf_flag_bank ssf_flag_bank_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .faults(faults),
  .pass_tick(pass_tick), .rtc_set_time(rtc_set_time),
  .rtc_set_strobe(rtc_set_strobe), .battery_indicator(battery_indicator)
);
`default_nettype wire

// ===== testbench/ssf_flag_bank_tb.sv
// testbench: self-checking scenarios for the flag bank
`timescale 1ns/1ns
`default_nettype none
module ssf_flag_bank_tb;
  logic                   hclk = 1'b0;
  logic                   hresetn;
  logic                   hsel;
  logic                   hwrite;
  logic                   pass_tick;
  logic [31:0]            haddr;
  logic [31:0]            hwdata;
  logic [31:0]            rtc_time_bcd;
  logic [31:0]            set_seen;
  logic [1:0]             htrans;
  ssf_pkg::ssf_fault_type faults;
  wire logic [31:0]       hrdata;
  wire logic [31:0]       rtc_set_time;
  wire logic              hreadyout;
  wire logic              rtc_set_strobe;
  wire logic              battery_indicator;
  wire logic              irq;
  int                     error_cnt = 0;
  int                     samples_checked = 0;
  int                     strobe_cnt = 0;

  ssf_flag_bank uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(), .faults(faults), .pass_tick(pass_tick),
    .rtc_time_bcd(rtc_time_bcd), .rtc_set_time(rtc_set_time),
    .rtc_set_strobe(rtc_set_strobe),
    .battery_indicator(battery_indicator), .irq(irq)
  );

  always #2 hclk = ~hclk;
  // count pulses at the edge so a one-cycle strobe is never missed
  always @(posedge hclk) begin
    if (rtc_set_strobe === 1'b1) begin
      strobe_cnt++;
      set_seen = rtc_set_time;
    end
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // master waits on hready, never on a fixed latency
  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    cmp(nm, e, r);
  endtask
  task automatic tick;
    @(posedge hclk);
    pass_tick <= 1'b1;
    @(posedge hclk);
    pass_tick <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  task automatic settle;
    repeat (2) @(negedge hclk);
  endtask
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  task automatic t_reset;
    rchk("control", ssf_pkg::OFF_CONTROL, 32'h0);
    rchk("irq en", ssf_pkg::OFF_IRQ_EN, 32'h0);
    wr(12'h100, 32'hFFFF_FFFF);
    rchk("unmapped", 12'h100, 32'h0);
    wr(ssf_pkg::OFF_STATUS, 32'h0000_007F);
    rchk("status ro", ssf_pkg::OFF_STATUS, 32'h0);
  endtask
  task automatic t_sticky;
    wr(ssf_pkg::OFF_IRQ_EN, 32'h0000_007F);
    faults <= 5'b10011;
    repeat (3) @(posedge hclk);
    faults <= '0;
    repeat (3) @(posedge hclk);
    rchk("status", ssf_pkg::OFF_STATUS, 32'h31);
    rchk("irq stat", ssf_pkg::OFF_IRQ_STAT, 32'h31);
    cmp("irq", 1, irq);
    wr(ssf_pkg::OFF_IRQ_EN, 32'h0);
    settle;
    cmp("irq masked", 0, irq);
    wr(ssf_pkg::OFF_IRQ_EN, 32'h0000_007F);
    settle;
    cmp("irq unmasked", 1, irq);
    wr(ssf_pkg::OFF_IRQ_CLR, 32'h31);
    settle;
    cmp("irq cleared", 0, irq);
    rchk("status held", ssf_pkg::OFF_STATUS, 32'h31);
  endtask
  task automatic t_battery;
    faults.battery_low <= 1'b1;
    repeat (4) @(posedge hclk);
    rchk("bat unused", ssf_pkg::OFF_STATUS, 32'h31);
    cmp("ind unused", 0, battery_indicator);
    wr(ssf_pkg::OFF_CONTROL, 32'h4);
    repeat (4) @(posedge hclk);
    rchk("bat low", ssf_pkg::OFF_STATUS, 32'h3D);
    cmp("ind low", 1, battery_indicator);
    faults.battery_low <= 1'b0;
    repeat (4) @(posedge hclk);
    rchk("bat back", ssf_pkg::OFF_STATUS, 32'h39);
    cmp("ind latched", 1, battery_indicator);
  endtask
  // drop then raise the write request; the edge shows a pass late
  task automatic req_edge;
    wr(ssf_pkg::OFF_CONTROL, 32'h4);
    tick;
    wr(ssf_pkg::OFF_CONTROL, 32'h5);
    tick;
    tick;
  endtask
  task automatic t_clk_write;
    int n;
    n = strobe_cnt;
    wr(ssf_pkg::OFF_CLK_WORD0, 32'h12);
    wr(ssf_pkg::OFF_CLK_WORD1, 32'h34);
    wr(ssf_pkg::OFF_CLK_WORD2, 32'h56);
    wr(ssf_pkg::OFF_CLK_WORD3, 32'h07);
    wr(ssf_pkg::OFF_CONTROL, 32'h5);
    repeat (8) @(posedge hclk);
    cmp("no pass no set", n, strobe_cnt);
    tick;
    cmp("first pass samples", n, strobe_cnt);
    tick;
    cmp("set strobes", n + 1, strobe_cnt);
    cmp("set time", 32'h0756_3412, set_seen);
    rchk("no data err", ssf_pkg::OFF_STATUS, 32'h39);
    tick;
    cmp("steady level", n + 1, strobe_cnt);
    wr(ssf_pkg::OFF_CLK_WORD1, 32'h3A);
    req_edge;
    cmp("bad data", n + 1, strobe_cnt);
    rchk("data err", ssf_pkg::OFF_STATUS, 32'h79);
    wr(ssf_pkg::OFF_CLK_WORD1, 32'h34);
    req_edge;
    cmp("good again", n + 2, strobe_cnt);
    cmp("set time again", 32'h0756_3412, set_seen);
    rchk("data err clear", ssf_pkg::OFF_STATUS, 32'h39);
  endtask
  task automatic t_clk_read;
    rtc_time_bcd <= 32'h2359_4512;
    wr(ssf_pkg::OFF_CONTROL, 32'h6);
    tick;
    tick;
    for (int i = 0; i < 4; i++) begin
      rchk("word", ssf_pkg::OFF_CLK_WORD0 + 12'(4 * i),
           {24'h0, rtc_time_bcd[8*i +: 8]});
    end
    wr(ssf_pkg::OFF_CONTROL, 32'h4);
    tick;
    rtc_time_bcd <= 32'h0000_0001;
    tick;
    rchk("word held", ssf_pkg::OFF_CLK_WORD0, 32'h12);
  endtask
  // a short loss must latch; a full window would cost millions of cycles
  task automatic t_power(input logic [31:0] ctl);
    do_reset;
    rchk("pd cleared", ssf_pkg::OFF_STATUS, 32'h0);
    wr(ssf_pkg::OFF_CONTROL, ctl);
    faults.supply_lost <= 1'b1;
    repeat (10) @(posedge hclk);
    faults.supply_lost <= 1'b0;
    repeat (20) @(posedge hclk);
    rchk("power down", ssf_pkg::OFF_STATUS, 32'h2);
  endtask

  initial begin
    {hresetn, hsel, hwrite, pass_tick, htrans} = '0;
    {haddr, hwdata, rtc_time_bcd} = '0;
    faults = '0;
    do_reset;
    t_reset;
    t_sticky;
    t_battery;
    t_clk_write;
    t_clk_read;
    t_power(32'h0);
    t_power(32'h8);
    end_of_test;
  end
  initial begin
    #20000;
    error_cnt++;
    end_of_test;
  end
endmodule
`default_nettype wire
